// [tb/board_pins.sv]
`timescale 1ns/1ns
module board_pins
	import gpio_pkg::*;
(
	// Device side
	input  wire logic [PIN_COUNT-1:0] gpio_out,
	input  wire logic [PIN_COUNT-1:0] gpio_oe_n,
	// Board side
	input  wire logic [PIN_COUNT-1:0] ext_level,
	input  wire logic [PIN_COUNT-1:0] ext_en,
	output logic      [PIN_COUNT-1:0] pad
);
	// Undriven pins float to the pull-up; device drive wins, contention not modelled
	assign pad = (~gpio_oe_n & gpio_out) | (gpio_oe_n & ((ext_en & ext_level) | ~ext_en));
endmodule

// [tb/gpio_port_assertions.sv]
`timescale 1ns/1ns
module gpio_port_checker
	import gpio_pkg::*;
#(
	parameter int unsigned PINS = PIN_COUNT
) (
	// Watched ports
	input wire logic            core_clk,
	input wire logic            sys_rst,
	input wire cfg_req_t        cfg_req,
	input wire cfg_rsp_t        cfg_rsp,
	input wire logic [PINS-1:0] gpio_in,
	input wire logic [PINS-1:0] gpio_oe_n,
	input wire logic            expander_irq_in_a_n,
	input wire logic            expander_irq_in_c_n
);
	wire logic wr_take = cfg_req.valid & cfg_req.write;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_read; cfg_req.valid && !cfg_req.write; endsequence
	sequence s_other_read; s_read ##0 cfg_req.index > IDX_PIN_DATA; endsequence
	a_ack_follows: assert property (cfg_req.valid |=> cfg_rsp.ack)
		else $error("ack missing");
	a_ack_unasked: assert property (!cfg_req.valid |=> !cfg_rsp.ack)
		else $error("stray ack");
	a_upper_zero: assert property (cfg_rsp.ack |-> cfg_rsp.rdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	a_unmapped_zero: assert property (s_other_read |=> cfg_rsp.rdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!cfg_req.valid |=> $stable(cfg_rsp.rdata))
		else $error("read data moved");
	a_drive_after_write: assert property ($changed(gpio_oe_n) |-> $past(wr_take, 2))
		else $error("drive changed without write");
	a_reset_idle: assert property ($fell(sys_rst) |-> gpio_oe_n == '1 && expander_irq_in_a_n && expander_irq_in_c_n)
		else $error("not idle after reset");
	a_irq_a_pad: assert property (!expander_irq_in_a_n |-> !$past(gpio_in[PIN_EXPANDER_A], 3))
		else $error("irq a without pad");
	a_irq_c_pad: assert property (!expander_irq_in_c_n |-> !$past(gpio_in[PIN_EXPANDER_C], 3))
		else $error("irq c without pad");
endmodule

bind switch_gpio_port gpio_port_checker #(.PINS(PINS)) i_checker (.core_clk, .sys_rst, .cfg_req, .cfg_rsp,
	.gpio_in, .gpio_oe_n, .expander_irq_in_a_n, .expander_irq_in_c_n);

// [tb/testbench.sv]
`timescale 1ns/1ns
module testbench;
	import gpio_pkg::*;
	logic        core_clk, sys_rst, src_a, src_b, src_c, src_ev, irq_a_n, irq_c_n;
	cfg_req_t    cfg_req;
	cfg_rsp_t    cfg_rsp;
	logic [15:0] gpio_in, gpio_out, gpio_oe_n, ext_level, ext_en, fm, dm, vm, sv, drv, xp;
	logic [31:0] rd, w;
	logic [3:0]  be;
	int          n_fail, checked, k, j;

	switch_gpio_port i_dut (.core_clk, .sys_rst, .cfg_req, .cfg_rsp, .gpio_in, .gpio_out, .gpio_oe_n,
		.downstream_port_a_reset_out_n(src_a), .downstream_port_b_reset_out_n(src_b),
		.downstream_port_c_reset_out_n(src_c), .event_out_n(src_ev),
		.expander_irq_in_a_n(irq_a_n), .expander_irq_in_c_n(irq_c_n));
	board_pins i_board (.gpio_out, .gpio_oe_n, .ext_level, .ext_en, .pad(gpio_in));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic complete_run();
		if (n_fail == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cfg(input logic wr, input logic [9:0] idx, input logic [3:0] bm, input logic [31:0] wd);
		int i;
		@(negedge core_clk);
		cfg_req <= '{1'b1, wr, idx, bm, wd};
		@(negedge core_clk);
		cfg_req.valid <= 1'b0;
		for (i = 0; cfg_rsp.ack !== 1'b1; i++) begin
			if (i == 4) begin
				n_fail++;
				complete_run();
			end
			@(negedge core_clk);
		end
		rd = cfg_rsp.rdata;
	endtask

	function automatic logic [15:0] mrg(input logic [15:0] o, input logic [15:0] n, input logic [3:0] bm);
		return {bm[1] ? n[15:8] : o[15:8], bm[0] ? n[7:0] : o[7:0]};
	endfunction

	// Wait past two sync flops plus one full sample interval before judging
	task automatic check_pins();
		sv = {4'h0, src_c, 3'h0, src_ev, 5'h0, src_b, src_a};
		drv = (~fm & dm) | (fm & 16'h0883);
		xp = (drv & ((fm & sv) | (~fm & vm))) | (~drv & ((ext_en & ext_level) | ~ext_en));
		repeat (20) @(negedge core_clk);
		chk(gpio_oe_n, ~drv);
		chk(gpio_out & drv, xp & drv);
		chk({14'h0, irq_c_n, irq_a_n}, {14'h0, ~fm[4] | xp[4], ~fm[2] | xp[2]});
		cfg(1'b0, IDX_PIN_DATA, 4'hf, 32'h0);
		chk(rd[15:0], xp);
		cfg(1'b0, IDX_PIN_FUNCTION_SELECT, 4'hf, 32'h0);
		chk(rd[15:0], fm);
		cfg(1'b0, IDX_PIN_DIRECTION_CONFIG, 4'hf, 32'h0);
		chk(rd[15:0], dm);
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		void'($urandom(50218));
		{sys_rst, src_a, src_b, src_c, src_ev} = 5'h1f;
		cfg_req = '0;
		{ext_level, ext_en, fm, dm, vm} = {16'h0, 16'hffff, 48'h0};
		{n_fail, checked} = 0;
		repeat (17) @(negedge core_clk);
		sys_rst = 1'b0;
		cfg(1'b1, 10'h3ff, 4'hf, 32'hffff_ffff);
		cfg(1'b0, 10'h3ff, 4'hf, 32'h0);
		chk(rd[15:0], 16'h0000);
		check_pins();
		for (k = 0; k < 40; k++) begin
			ext_level = 16'($urandom);
			ext_en = 16'($urandom);
			{src_a, src_b, src_c, src_ev} = 4'($urandom);
			for (j = 0; j < 3; j++) begin
				w = $urandom;
				be = (k < 4) ? 4'(k + 1) : 4'($urandom);
				cfg(1'b1, IDX_PIN_FUNCTION_SELECT + 10'(j), be, w);
				if (j == 0)
					fm = mrg(fm, w[15:0], be);
				else if (j == 1)
					dm = mrg(dm, w[15:0], be);
				else
					vm = mrg(vm, w[15:0], be);
			end
			check_pins();
		end
		@(negedge core_clk);
		sys_rst = 1'b1;
		repeat (3) @(negedge core_clk);
		sys_rst = 1'b0;
		{fm, dm, vm} = 48'h0;
		check_pins();
		complete_run();
	end
endmodule

// [verilog/gpio_pkg.sv]
package gpio_pkg;

	// ---------------------------------------------------------------
	// Geometry and clocking
	// ---------------------------------------------------------------
	localparam int unsigned PIN_COUNT      = 16;
	localparam int unsigned CLK_PERIOD_NS  = 10;
	// Least spacing between two input samples
	localparam int unsigned SAMPLE_MIN_NS  = 128;
	localparam int unsigned SAMPLE_CYCLES  = (SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SAMPLE_CNT_W   = $clog2(SAMPLE_CYCLES);
	localparam logic [SAMPLE_CNT_W-1:0] SAMPLE_RELOAD = SAMPLE_CNT_W'(SAMPLE_CYCLES - 1);

	// ---------------------------------------------------------------
	// Configuration space placement (dword indices)
	// ---------------------------------------------------------------
	localparam int unsigned CFG_INDEX_W    = 10;
	localparam logic [CFG_INDEX_W-1:0] IDX_PIN_FUNCTION_SELECT = 10'h0c8;
	localparam logic [CFG_INDEX_W-1:0] IDX_PIN_DIRECTION_CONFIG = 10'h0c9;
	localparam logic [CFG_INDEX_W-1:0] IDX_PIN_DATA            = 10'h0ca;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] RST_FUNCTION_SELECT  = 16'h0000;
	localparam logic [15:0] RST_DIRECTION_CONFIG = 16'h0000;
	localparam logic [15:0] RST_DATA             = 16'h0000;
	localparam logic [31:0] RST_READ_DATA        = 32'h0000_0000;

	// ---------------------------------------------------------------
	// Pins that carry an alternate function
	// ---------------------------------------------------------------
	localparam int unsigned PIN_PORT_A_RESET = 0;
	localparam int unsigned PIN_PORT_B_RESET = 1;
	localparam int unsigned PIN_EXPANDER_A   = 2;
	localparam int unsigned PIN_EXPANDER_C   = 4;
	localparam int unsigned PIN_EVENT        = 7;
	localparam int unsigned PIN_PORT_C_RESET = 11;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_INPUT,
		MODE_OUTPUT,
		MODE_ALTERNATE
	} pin_mode_t;

	typedef struct packed {
		logic                   valid;
		logic                   write;
		logic [CFG_INDEX_W-1:0] index;
		logic [3:0]             byte_en;
		logic [31:0]            wdata;
	} cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdata;
	} cfg_rsp_t;

endpackage

// [verilog/switch_gpio_port.sv]
// Function
// - Sixteen pins, each input, output or alternate.
// - Each pin owns one bit per register.
// - Function bit set means alternate; else direction decides.
// - Reset puts every pin in general input.
// - Synchronize inputs; sample at most every 128 ns.
// - General mode forces alternate signal inactive internally.
// - Input mode captures sampled level into data.
// - Data read returns sampled pin level always.
// - Output mode drives pin from data bit.
// - Pins 0,1,11 alternate: downstream reset outputs.
// - Pins 2,4 alternate: expander interrupt inputs.
// - Pin 7 alternate: event output.
// - Registers reached by configuration space accesses.
// - Alternate pin level readable through data register.
`timescale 1ns/1ns

module switch_gpio_port
	import gpio_pkg::*;
#(
	parameter int unsigned PINS = PIN_COUNT
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              sys_rst,
	// Configuration access from the upstream port
	input  wire cfg_req_t          cfg_req,
	output cfg_rsp_t               cfg_rsp,
	// Pads
	input  wire logic [PINS-1:0]   gpio_in,
	output logic      [PINS-1:0]   gpio_out,
	output logic      [PINS-1:0]   gpio_oe_n,
	// Alternate function sources from the switch core
	input  wire logic              downstream_port_a_reset_out_n,
	input  wire logic              downstream_port_b_reset_out_n,
	input  wire logic              downstream_port_c_reset_out_n,
	input  wire logic              event_out_n,
	// Alternate function inputs toward the switch core
	output logic                   expander_irq_in_a_n,
	output logic                   expander_irq_in_c_n
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [PINS-1:0]         pin_function_select;
	logic [PINS-1:0]         pin_direction_config;
	logic [PINS-1:0]         out_value;
	logic [PINS-1:0]         sync_first;
	logic [PINS-1:0]         sync_second;
	logic [PINS-1:0]         sampled;
	logic [SAMPLE_CNT_W-1:0] sample_cnt;

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	wire logic hit_func  = cfg_req.index == IDX_PIN_FUNCTION_SELECT;
	wire logic hit_dir   = cfg_req.index == IDX_PIN_DIRECTION_CONFIG;
	wire logic hit_data  = cfg_req.index == IDX_PIN_DATA;
	wire logic do_write  = cfg_req.valid && cfg_req.write;
	wire logic do_read   = cfg_req.valid && !cfg_req.write;

	// Write strobes, one per register
	wire logic wr_func   = do_write && hit_func;
	wire logic wr_dir    = do_write && hit_dir;
	wire logic wr_data   = do_write && hit_data;

	// Byte lanes 0 and 1 carry the sixteen pin bits
	wire logic [PINS-1:0] lane_mask = {{8{cfg_req.byte_en[1]}}, {8{cfg_req.byte_en[0]}}};
	wire logic [PINS-1:0] wr_bits   = cfg_req.wdata[PINS-1:0];

	wire logic [PINS-1:0] next_function_select =
		(pin_function_select & ~lane_mask) | (wr_bits & lane_mask);
	wire logic [PINS-1:0] next_direction_config =
		(pin_direction_config & ~lane_mask) | (wr_bits & lane_mask);
	// Data writes land in the output latch in every mode
	wire logic [PINS-1:0] next_out_value =
		(out_value & ~lane_mask) | (wr_bits & lane_mask);

	// Unmapped indices read as zero and swallow writes
	wire logic [31:0] read_mux =
		hit_func ? {16'h0000, pin_function_select} :
		hit_dir  ? {16'h0000, pin_direction_config} :
		hit_data ? {16'h0000, sampled} :
		           32'h0000_0000;

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	// A write here can hand a pin to the core two cycles after the request
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pin_function_select <= RST_FUNCTION_SELECT;
		end else if (wr_func) begin
			pin_function_select <= next_function_select;
		end
	end

	// Direction only matters while the function bit is clear
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pin_direction_config <= RST_DIRECTION_CONFIG;
		end else if (wr_dir) begin
			pin_direction_config <= next_direction_config;
		end
	end

	// Written in any mode so software can preset a level before turning the drive on
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			out_value <= RST_DATA;
		end else if (wr_data) begin
			out_value <= next_out_value;
		end
	end

	// Answer one cycle after the request; read data holds until the next read
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cfg_rsp.ack   <= 1'b0;
			cfg_rsp.rdata <= RST_READ_DATA;
		end else begin
			cfg_rsp.ack <= cfg_req.valid;
			if (do_read)
				cfg_rsp.rdata <= read_mux;
		end
	end

	// ---------------------------------------------------------------
	// Input synchronizer and slow sampler
	// ---------------------------------------------------------------
	// Pads are asynchronous; two flops before anything looks at them
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sync_first  <= '0;
			sync_second <= '0;
		end else begin
			sync_first  <= gpio_in;
			sync_second <= sync_first;
		end
	end

	// ---------------------------------------------------------------
	// Sample interval
	// ---------------------------------------------------------------
	wire logic                    sample_tick     = sample_cnt == '0;
	wire logic [SAMPLE_CNT_W-1:0] next_sample_cnt = sample_tick ? SAMPLE_RELOAD : SAMPLE_CNT_W'(sample_cnt - 1'b1);

	// Spacing samples by at least 128 ns filters short glitches on slow board signals
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sample_cnt <= SAMPLE_RELOAD;
			sampled    <= RST_DATA;
		end else begin
			sample_cnt <= next_sample_cnt;
			if (sample_tick)
				sampled <= sync_second;
		end
	end

	// ---------------------------------------------------------------
	// Per-pin mode decode and drive
	// ---------------------------------------------------------------
	// Alternate output sources by pin; pins without one stay undriven
	wire logic [PINS-1:0] alt_value;
	wire logic [PINS-1:0] next_gpio_out;
	wire logic [PINS-1:0] next_gpio_oe_n;

	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			// Only pins 0, 1, 7 and 11 carry a core signal out to the pad
			localparam bit HAS_ALT = (g == PIN_PORT_A_RESET) || (g == PIN_PORT_B_RESET) ||
			                         (g == PIN_PORT_C_RESET) || (g == PIN_EVENT);

			assign alt_value[g] =
				(g == PIN_PORT_A_RESET) ? downstream_port_a_reset_out_n :
				(g == PIN_PORT_B_RESET) ? downstream_port_b_reset_out_n :
				(g == PIN_PORT_C_RESET) ? downstream_port_c_reset_out_n :
				(g == PIN_EVENT)        ? event_out_n :
				                          1'b1;

			pin_cell #(
				.HAS_ALT_OUT (HAS_ALT)
			) i_cell (
				.function_bit  (pin_function_select[g]),
				.direction_bit (pin_direction_config[g]),
				.data_bit      (out_value[g]),
				.alt_source_n  (alt_value[g]),
				.drive_value   (next_gpio_out[g]),
				.drive_off     (next_gpio_oe_n[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Pad output flops
	// ---------------------------------------------------------------
	// Registered pad drive: no combinational path from the core to the board
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gpio_out <= '0;
		end else begin
			gpio_out <= next_gpio_out;
		end
	end

	// Drive is off through reset so a pad cannot fight the board before setup
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			gpio_oe_n <= '1;
		end else begin
			gpio_oe_n <= next_gpio_oe_n;
		end
	end

	// ---------------------------------------------------------------
	// Alternate inputs toward the core
	// ---------------------------------------------------------------
	alt_input_gate i_irq_a (
		.core_clk     (core_clk),
		.sys_rst      (sys_rst),
		.function_bit (pin_function_select[PIN_EXPANDER_A]),
		.synced_level (sync_second[PIN_EXPANDER_A]),
		.irq_n        (expander_irq_in_a_n)
	);

	alt_input_gate i_irq_c (
		.core_clk     (core_clk),
		.sys_rst      (sys_rst),
		.function_bit (pin_function_select[PIN_EXPANDER_C]),
		.synced_level (sync_second[PIN_EXPANDER_C]),
		.irq_n        (expander_irq_in_c_n)
	);

endmodule

// ---------------------------------------------------------------
// One pad: mode decode and drive value
// ---------------------------------------------------------------
module pin_cell
	import gpio_pkg::*;
#(
	// Pin has a core signal to put on the pad
	parameter bit HAS_ALT_OUT = 1'b0
) (
	// Configuration bits of this pin
	input  wire logic function_bit,
	input  wire logic direction_bit,
	input  wire logic data_bit,
	// Alternate source, active low
	input  wire logic alt_source_n,
	// Pad controls ahead of the output flops
	output logic      drive_value,
	output logic      drive_off
);

	pin_mode_t mode;

	always_comb begin
		if (function_bit)
			mode = MODE_ALTERNATE;
		else if (direction_bit)
			mode = MODE_OUTPUT;
		else
			mode = MODE_INPUT;
	end

	// A pin whose alternate is an input never drives in alternate mode, or it would fight the board
	assign drive_value = (mode == MODE_OUTPUT)                   ? data_bit :
	                     (mode == MODE_ALTERNATE && HAS_ALT_OUT) ? alt_source_n :
	                     (mode == MODE_ALTERNATE)                ? 1'b1 : 1'b0;
	assign drive_off   = (mode == MODE_OUTPUT)    ? 1'b0 :
	                     (mode == MODE_ALTERNATE) ? !HAS_ALT_OUT : 1'b1;

endmodule

// ---------------------------------------------------------------
// Alternate input toward the core
// ---------------------------------------------------------------
module alt_input_gate (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// Pin state
	input  wire logic function_bit,
	input  wire logic synced_level,
	// Toward the core, active low
	output logic      irq_n
);

	// In general mode the interrupt is held negated so stray pad levels cannot fire it
	wire logic next_irq_n = function_bit ? synced_level : 1'b1;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= next_irq_n;
		end
	end

endmodule
